// ---- shared/asm_pkg.sv ----
// package for the host-side controller of the 256K x 8 static memory module
// assumes a 10 MHz system clock; all timings are rounded to whole cycles
package asm_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 100;
  // read cycle, write cycle, write pulse, address setup and write recovery, ns
  localparam int T_RC_NS = 150;
  localparam int T_WC_NS = 150;
  localparam int T_WP_NS = 100;
  localparam int T_AS_NS = 10;
  localparam int T_WR_NS = 10;
  localparam int T_ACC_NS = 150;
  localparam int T_CDR_NS = 30;
  localparam int T_OHZ_NS = 70;
  localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CDR_CYC = (T_CDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int OHZ_CYC = (T_OHZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asm_req_t;

  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr_lines;
  } asm_pins_t;
endpackage

// ---- logic/asm_host_ctrl.sv ----
// host-side controller driving the 256K x 8 static memory module pins
// assumes a user that issues single byte requests and a module whose data
// lines are combined with ours by the bench from the output enables
//
// Summary of operation
// - drive full 18-bit address every access
// - shared 8-bit bus, host drives writes
// - strobe kept high through read cycle
// - no access during lowered-supply retention
// - 30 ns deselect before, tRC after retention
`timescale 1ns/1ps
module asm_host_ctrl
  import asm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire asm_pkg::asm_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [asm_pkg::DATA_W-1:0] rsp_data_o,
  input wire logic retain_req_i,
  output logic retain_ok_o,
  output asm_pkg::asm_pins_t pins_o,
  input wire logic [asm_pkg::DATA_W-1:0] data_lines_i,
  output logic [asm_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o
);
  import asm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WSET, ST_WPULSE, ST_WHOLD, ST_RACC, ST_RFLOAT,
    ST_RETAIN, ST_RECOVER
  } asm_state_t;

  asm_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q;

  // three stage capture of the module's data lines
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= DATA_RST;
      sync2_q <= DATA_RST;
      sync3_q <= DATA_RST;
    end else begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (retain_req_i) begin
            state_q <= ST_RETAIN;
            cnt_q <= CNT_W'(CDR_CYC);
          end else if (req_valid_i) begin
            state_q <= req_i.write ? ST_WSET : ST_RACC;
            cnt_q <= req_i.write ? CNT_W'(AS_CYC) : CNT_W'(ACC_CYC + 2);
          end
        end
        ST_WSET: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_WPULSE;
            cnt_q <= CNT_W'(WP_CYC);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_WPULSE: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_WHOLD;
            cnt_q <= CNT_W'(WR_CYC);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_WHOLD: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_RACC: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_RFLOAT;
            cnt_q <= CNT_W'(OHZ_CYC);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_RFLOAT: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_RETAIN: begin
          if (cnt_q > CNT_W'(0)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else if (!retain_req_i) begin
            state_q <= ST_RECOVER;
            cnt_q <= CNT_W'(RC_CYC);
          end
        end
        ST_RECOVER: begin
          if (cnt_q == CNT_W'(1)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // pin drive, all outputs registered
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o.select_low_n <= 1'b1;
      pins_o.select_high <= 1'b0;
      pins_o.oe_n <= 1'b1;
      pins_o.we_n <= 1'b1;
      pins_o.addr_lines <= ADDR_RST;
      data_lines_o <= DATA_RST;
      data_lines_oe_n_o <= 1'b1;
    end else if (state_q == ST_IDLE && !retain_req_i && req_valid_i) begin
      pins_o.addr_lines <= req_i.addr;
      pins_o.select_low_n <= 1'b0;
      pins_o.select_high <= 1'b1;
      pins_o.oe_n <= req_i.write;
      pins_o.we_n <= 1'b1;
      data_lines_o <= req_i.wdata;
      data_lines_oe_n_o <= !req_i.write;
    end else begin
      unique case (state_q)
        ST_WSET: if (cnt_q == CNT_W'(1)) pins_o.we_n <= 1'b0;
        ST_WPULSE: if (cnt_q == CNT_W'(1)) pins_o.we_n <= 1'b1;
        ST_WHOLD: if (cnt_q == CNT_W'(1)) begin
          pins_o.select_low_n <= 1'b1;
          pins_o.select_high <= 1'b0;
          data_lines_oe_n_o <= 1'b1;
        end
        ST_RACC: if (cnt_q == CNT_W'(1)) begin
          pins_o.oe_n <= 1'b1;
          pins_o.select_low_n <= 1'b1;
          pins_o.select_high <= 1'b0;
        end
        default: begin
          pins_o.we_n <= 1'b1;
        end
      endcase
    end
  end

  // user side answers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= DATA_RST;
      req_ready_o <= 1'b0;
      retain_ok_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_q == ST_RACC) && (cnt_q == CNT_W'(1));
      if (state_q == ST_RACC && cnt_q == CNT_W'(1)) begin
        rsp_data_o <= sync3_q;
      end
      req_ready_o <= (state_q == ST_IDLE) && !req_valid_i && !retain_req_i;
      retain_ok_o <= (state_q == ST_RETAIN) && (cnt_q == CNT_W'(0));
    end
  end

  // assertions
  a_write_no_oe: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pins_o.we_n |-> pins_o.oe_n && !data_lines_oe_n_o)
    else $error("write strobe low without host drive or with oe low");
  a_read_we_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pins_o.oe_n |-> pins_o.we_n && data_lines_oe_n_o)
    else $error("read with strobe low or host driving");
  a_sel_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pins_o.select_low_n == !pins_o.select_high)
    else $error("selects disagree");
  a_strobe_in_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pins_o.we_n) |-> !pins_o.select_low_n [*2])
    else $error("strobe pulse outside selection");
  a_addr_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pins_o.select_low_n && $past(!pins_o.select_low_n)
      |-> $stable(pins_o.addr_lines))
    else $error("address moved during access");
  a_retain_desel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    retain_ok_o |-> pins_o.select_low_n && $past(pins_o.select_low_n))
    else $error("retention allowed while selected");
  a_read_answer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pins_o.oe_n) |-> ##[1:4] rsp_valid_o)
    else $error("read answer late");
  a_recover_gap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(retain_ok_o) |-> pins_o.select_low_n [*2])
    else $error("access too soon after retention");
  c_write: cover property (@(posedge mclk_i) $rose(pins_o.we_n));
  c_read: cover property (@(posedge mclk_i) rsp_valid_o);
  c_retain: cover property (@(posedge mclk_i) retain_ok_o);
  c_recover: cover property (@(posedge mclk_i) $fell(retain_ok_o));
endmodule

// ---- tb/asm_sram_model.sv ----
// device model: 256K x 8 static memory module behind the host pins
// assumes the bench resolves the shared data bus from both enables
`timescale 1ns/1ps
module asm_sram_model
  import asm_pkg::*;
(
  input wire asm_pkg::asm_pins_t pins_i,
  input wire logic [asm_pkg::DATA_W-1:0] bus_i,
  output logic [asm_pkg::DATA_W-1:0] data_o,
  output logic drive_o
);
  // no clock, no refresh: contents simply persist
  logic [DATA_W-1:0] mem [0:262143];
  logic sel;
  logic [2:0] chip;
  assign sel = !pins_i.select_low_n && pins_i.select_high;
  assign chip = pins_i.addr_lines[17:15];
  always @(posedge pins_i.we_n) begin
    if (sel) begin
      mem[{chip, pins_i.addr_lines[14:0]}] = bus_i;
    end
  end
  // output enable high or strobe low keeps the lines floating
  assign drive_o = sel && !pins_i.oe_n
    && pins_i.we_n;
  assign data_o = mem[pins_i.addr_lines];
endmodule

// ---- tb/test_asm_host_ctrl.sv ----
// bench for the host controller against the memory module model
// assumes the model is compiled first
`timescale 1ns/1ps
module test_asm_host_ctrl;
  import asm_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, req_valid_i = 0, retain_req_i = 0;
  asm_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, retain_ok_o, data_lines_oe_n_o, m_drv;
  logic [DATA_W-1:0] rsp_data_o, data_lines_o, m_data, bus, rd;
  logic [DATA_W-1:0] last = 8'h00;
  asm_pins_t pins_o;
  int bad_count = 0, checks_done = 0;
  always #50 mclk_i = ~mclk_i;
  // a released bus shows the inverse of its last value
  assign bus = !data_lines_oe_n_o ? data_lines_o : m_drv ? m_data : ~last;
  always @(posedge mclk_i) last <= bus;
  asm_host_ctrl asm_host_ctrl_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .retain_req_i(retain_req_i), .retain_ok_o(retain_ok_o), .pins_o(pins_o),
    .data_lines_i(bus), .data_lines_o(data_lines_o),
    .data_lines_oe_n_o(data_lines_oe_n_o));
  asm_sram_model asm_sram_model_inst (.pins_i(pins_o), .bus_i(bus),
    .data_o(m_data), .drive_o(m_drv));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    give_verdict();
  endtask
  always @(negedge mclk_i) begin
    if (rst_n_i) begin
      chk("contention", 32'(m_drv & !data_lines_oe_n_o),
        0);
      chk("strobe in read", 32'(pins_o.oe_n | pins_o.we_n), 1);
    end
  end
  function automatic logic [17:0] adr(int i);
    return (i == 8) ? 18'h3ffff : {i[2:0], 15'h02a5};
  endfunction
  function automatic logic [7:0] dat(int i);
    return 8'h3c ^ (8'(i) * 8'h11);
  endfunction
  task automatic op(logic wr, logic [17:0] a, logic [7:0] d);
    int n;
    n = 0;
    // ready is only a hint: wait for it with valid low, then present once
    do begin
      @(posedge mclk_i);
      if (++n > 40) hang();
    end while (req_ready_o !== 1'b1);
    req_i <= '{wr, a, d};
    req_valid_i <= 1'b1;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    if (!wr) begin
      n = 0;
      do begin
        @(posedge mclk_i);
        if (++n > 20) hang();
      end while (rsp_valid_o !== 1'b1);
      chk("read latency", n, 5);
      rd = rsp_data_o;
      @(posedge mclk_i);
      chk("valid pulse", 32'(rsp_valid_o), 0);
    end
  endtask
  task automatic t_chips();
    for (int i = 0; i < 9; i++) op(1'b1, adr(i), dat(i));
    for (int i = 0; i < 9; i++) begin
      op(1'b0, adr(i), 8'h00);
      chk("read back", rd, dat(i));
    end
  endtask
  task automatic t_retain();
    int n;
    @(posedge mclk_i);
    retain_req_i <= 1'b1;
    req_i <= '{1'b1, adr(0), 8'hff};
    req_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      if (++n > 20) hang();
      chk("retain select", 32'(pins_o.select_low_n), 1);
    end while (retain_ok_o !== 1'b1);
    chk("deselect time", 32'(n > 1), 1);
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    retain_req_i <= 1'b0;
    op(1'b0, adr(0), 8'h00);
    chk("retained data", rd, dat(0));
  endtask
  initial begin
    @(negedge mclk_i);
    chk("reset pins", 32'(pins_o), 32'({4'hb, 18'h0}));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_chips();
    t_retain();
    give_verdict();
  end
endmodule
